// >>> ntm_pkg.sv
// Shared constants and types for the maintenance channel and scrambler block.
package ntm_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_RXF  = 8'h08;
	localparam logic [7:0] ADDR_TXF  = 8'h0C;
	localparam logic [7:0] ADDR_SEED = 8'h10;

	// Control register fields and reset value.
	localparam int         CTRL_RTN      = 0;
	localparam int         CTRL_BLOOP_EN = 1;
	localparam int         CTRL_SEED_LD  = 2;
	localparam logic [1:0] CTRL_RST      = 2'h2;

	// Status register fields.
	localparam int ST_LOOP_ALL = 0;
	localparam int ST_LOOP_B1  = 1;
	localparam int ST_LOOP_B2  = 2;
	localparam int ST_CRC_REQ  = 3;
	localparam int ST_CRC_NOTE = 4;
	localparam int ST_REP_LSB  = 5;
	localparam int ACT_W       = 5;

	// ****************************************************************
	// Maintenance frame layout and codes
	// ****************************************************************
	localparam int         FR_W        = 12;
	localparam int         FR_ADDR_LSB = 9;
	localparam int         FR_FLAG     = 8;
	localparam logic [2:0] NODE_ADDR   = 3'h0;
	localparam logic [2:0] BCAST_ADDR  = 3'h7;
	localparam logic [7:0] MSG_LOOP_ALL = 8'h50;
	localparam logic [7:0] MSG_LOOP_B1  = 8'h51;
	localparam logic [7:0] MSG_LOOP_B2  = 8'h52;
	localparam logic [7:0] MSG_CRC_REQ  = 8'h53;
	localparam logic [7:0] MSG_CRC_NOTE = 8'h54;
	localparam logic [7:0] MSG_RTN      = 8'hFF;
	localparam logic [7:0] MSG_HOLD     = 8'h00;
	localparam logic [7:0] MSG_UTC      = 8'hAA;

	// Slot codes carried beside each user bit.
	localparam logic [1:0] CH_B1  = 2'h0;
	localparam logic [1:0] CH_B2  = 2'h1;
	localparam logic [1:0] CH_D   = 2'h2;
	localparam logic [1:0] CH_OVH = 2'h3;

	// ****************************************************************
	// Scrambler
	// ****************************************************************
	localparam int          SCR_LEN  = 23;
	localparam int          TAP_DOWN = 5;
	localparam int          TAP_UP   = 18;
	localparam logic [22:0] SEED_RST = 23'h000001;
	localparam logic [22:0] SEED_ONES = 23'h7FFFFF;

	// Count of identical, addressed frames seen in a row, Gray coded.
	typedef enum logic [1:0]
	{
		NTM_REP0 = 2'h0,
		NTM_REP1 = 2'h1,
		NTM_REP2 = 2'h3,
		NTM_REP3 = 2'h2
	} ntm_rep_t;

endpackage

// >>> ntm_scr_if.sv
// Carrier between the block top and one scrambler or descrambler.
interface ntm_scr_if;
	logic        din;
	logic        din_valid;
	logic        freeze;
	logic        seed_load;
	logic [22:0] seed;
	logic        dout;
	logic        dout_valid;

	modport user
	(
		output din, din_valid, freeze, seed_load, seed,
		input  dout, dout_valid
	);
	modport core
	(
		input  din, din_valid, freeze, seed_load, seed,
		output dout, dout_valid
	);
endinterface

// >>> ntm_scrambler.sv
// Self-synchronising scrambler or descrambler with taps at TAP and 23.
module ntm_scrambler #(
	parameter int TAP     = ntm_pkg::TAP_UP,
	parameter bit DESCRAM = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	ntm_scr_if.core  io
);
	logic [22:0] sr_r;
	logic        fb;
	logic        outb;

	if (TAP < 1 || TAP >= ntm_pkg::SCR_LEN)
	begin : g_chk
		$error("Scrambler tap out of range.");
	end

	// Feedback from delays TAP and 23; sr_r[0] holds the last bit.
	assign fb   = sr_r[TAP-1] ^ sr_r[ntm_pkg::SCR_LEN-1];
	assign outb = io.din ^ fb;

	// The register shifts only on live bits outside the frame word.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sr_r <= ntm_pkg::SEED_RST;
		else if (io.seed_load)
			sr_r <= io.seed;
		else if (io.din_valid && !io.freeze)
			sr_r <= {sr_r[21:0], DESCRAM ? io.din : outb};
	end

	// Output bit is registered; frame word bits pass unscrambled.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			io.dout       <= 1'b0;
			io.dout_valid <= 1'b0;
		end
		else
		begin
			io.dout       <= io.freeze ? io.din : outb;
			io.dout_valid <= io.din_valid;
		end
	end
endmodule

// >>> ntm_top.sv
// Network terminal maintenance message processor with line scramblers.
//
// Operation
// - Accept frames addressed 000 or 111 only.
// - Cannot-comply reply carries own address 000.
// - Code 50 loops both bearers and signalling.
// - Codes 51, 52 loop one bearer, optional.
// - Single loop leaves activation ready bit alone.
// - Code FF clears all latched actions.
// - Code AA means validated but unsupported.
// - Code 53 corrupts outgoing checksums until cleared.
// - Code 00 keeps processor and actions unchanged.
// - Wrongly addressed frame answered with hold code.
// - Non-standard code blocks treated as unrecognised.
// - Network and future codes also unrecognised.
// - Extensions never disturb the echo protocol.
// - Each direction scrambled with 23rd order polynomial.
// - Downstream polynomial taps at five and 23.
// - Upstream polynomial taps at 18 and 23.
// - Receiver descrambles with the sender's polynomial.
// - User bits enter scrambler with unchanged polarity.
// - Shift registers freeze during frame words.
// - Scrambler never starts from all ones.
// - Frame: 3 address, 1 flag, 8 info bits.
// - Act after three identical frames; echo each.
// - Third unrecognised repeat answered with cannot-comply.
// - Transceiver reset states release all latched actions.
//
// Local design decisions: the APB slave port and the placing of the registers.
module ntm_top #(
	parameter bit BLOOP_SUPPORT = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [11:0] eoc_rx_frame,
	input  wire logic        eoc_rx_valid,
	output logic      [11:0] eoc_tx_frame,
	output logic             eoc_tx_valid,
	input  wire logic        xcvr_reset,
	input  wire logic        rx_line_bit,
	input  wire logic        rx_line_valid,
	input  wire logic        rx_frame_sync_word,
	input  wire logic [1:0]  rx_chan,
	output logic             rx_user_bit,
	output logic             rx_user_valid,
	output logic      [1:0]  rx_user_chan,
	input  wire logic        tx_user_bit,
	input  wire logic        tx_user_valid,
	input  wire logic        tx_frame_sync_word,
	input  wire logic [1:0]  tx_chan,
	output logic             tx_line_bit,
	output logic             tx_line_valid,
	output logic             loop_all,
	output logic             loop_first_bearer_channel,
	output logic             loop_second_bearer_channel,
	output logic             crc_corrupt,
	output logic             crc_corrupt_expected
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [1:0]                ctrl_r;
	logic                      rtn_sw;
	logic                      seed_ld;
	logic [22:0]               seed_r;
	logic [ntm_pkg::ACT_W-1:0] act_r;
	logic [ntm_pkg::ACT_W-1:0] act_set;
	logic                      act_clr;
	ntm_pkg::ntm_rep_t         rep_r;
	ntm_pkg::ntm_rep_t         rep_nxt;
	logic [11:0]               last_rx_r;
	logic [11:0]               tx_frame_r;
	logic [11:0]               tx_frame_nxt;
	logic                      tx_valid_r;
	logic [2:0]                fr_addr;
	logic                      fr_msg;
	logic [7:0]                fr_code;
	logic                      addr_ok;
	logic                      reached;
	logic                      recog;
	logic                      rtn_cmd;
	logic                      bloop_en;
	logic [3:0]                lb_mem_r;
	logic [1:0]                rx_chan_r;
	logic                      tx_in;
	logic                      wr_en;
	logic                      rd_en;
	logic                      unmapped;
	logic [31:0]               rd_data;
	logic [31:0]               prdata_r;

	ntm_scr_if up_if ();
	ntm_scr_if dn_if ();

	// ****************************************************************
	// Helper functions
	// ****************************************************************
	// Supported codes; all others, reserved blocks too, are unrecognised.
	function automatic logic msg_known(input logic [7:0] code, input logic single_ok);
		logic k;
		unique case (code)
			ntm_pkg::MSG_LOOP_ALL,
			ntm_pkg::MSG_CRC_REQ,
			ntm_pkg::MSG_CRC_NOTE,
			ntm_pkg::MSG_RTN,
			ntm_pkg::MSG_HOLD:    k = 1'b1;
			ntm_pkg::MSG_LOOP_B1,
			ntm_pkg::MSG_LOOP_B2: k = single_ok;
			default:              k = 1'b0;
		endcase
		return k;
	endfunction

	// True when the slot of a transmit bit is taken from the receive side.
	function automatic logic chan_looped(input logic [1:0] ch, input logic [4:0] act);
		logic l;
		l = 1'b0;
		if (ch != ntm_pkg::CH_OVH)
			l = act[ntm_pkg::ST_LOOP_ALL]
				| (act[ntm_pkg::ST_LOOP_B1] & (ch == ntm_pkg::CH_B1))
				| (act[ntm_pkg::ST_LOOP_B2] & (ch == ntm_pkg::CH_B2));
		return l;
	endfunction

	// ****************************************************************
	// Maintenance frame decode
	// ****************************************************************
	// Split the frame into address, flag and information field.
	assign fr_addr = eoc_rx_frame[ntm_pkg::FR_W-1:ntm_pkg::FR_ADDR_LSB];
	assign fr_msg  = eoc_rx_frame[ntm_pkg::FR_FLAG];
	assign fr_code = eoc_rx_frame[7:0];

	// Only the terminal and broadcast addresses are ours.
	assign addr_ok  = (fr_addr == ntm_pkg::NODE_ADDR) || (fr_addr == ntm_pkg::BCAST_ADDR);
	assign bloop_en = BLOOP_SUPPORT & ctrl_r[ntm_pkg::CTRL_BLOOP_EN];

	// Data frames are never recognised: no data transfer functions.
	assign recog   = fr_msg && msg_known(fr_code, bloop_en);
	assign reached = eoc_rx_valid && addr_ok && (rep_nxt == ntm_pkg::NTM_REP3);
	assign rtn_cmd = reached && recog && (fr_code == ntm_pkg::MSG_RTN);

	// Count identical addressed frames in a row, saturating at three.
	always_comb
	begin
		rep_nxt = rep_r;
		if (!addr_ok)
			rep_nxt = ntm_pkg::NTM_REP0;
		else if (eoc_rx_frame != last_rx_r || rep_r == ntm_pkg::NTM_REP0)
			rep_nxt = ntm_pkg::NTM_REP1;
		else
		begin
			unique case (rep_r)
				ntm_pkg::NTM_REP1: rep_nxt = ntm_pkg::NTM_REP2;
				ntm_pkg::NTM_REP2: rep_nxt = ntm_pkg::NTM_REP3;
				ntm_pkg::NTM_REP3: rep_nxt = ntm_pkg::NTM_REP3;
				default:           rep_nxt = ntm_pkg::NTM_REP1;
			endcase
		end
	end

	// Repetition state; return to normal puts it back to its start.
	always_ff @(posedge clk)
	begin
		if (!rst_n || xcvr_reset || rtn_cmd || rtn_sw)
		begin
			rep_r     <= ntm_pkg::NTM_REP0;
			last_rx_r <= 12'h000;
		end
		else if (eoc_rx_valid)
		begin
			rep_r     <= rep_nxt;
			last_rx_r <= eoc_rx_frame;
		end
	end

	// Reply: hold if foreign, cannot-comply on third unsupported, else echo.
	always_comb
	begin
		if (!addr_ok)
			tx_frame_nxt = {ntm_pkg::NODE_ADDR, 1'b1, ntm_pkg::MSG_HOLD};
		else if (reached && !recog)
			tx_frame_nxt = {ntm_pkg::NODE_ADDR, 1'b1, ntm_pkg::MSG_UTC};
		else
			tx_frame_nxt = eoc_rx_frame;
	end

	// Reply register, offered to the framer for the next return frame.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_frame_r <= {ntm_pkg::NODE_ADDR, 1'b1, ntm_pkg::MSG_HOLD};
			tx_valid_r <= 1'b0;
		end
		else
		begin
			tx_valid_r <= eoc_rx_valid;
			if (eoc_rx_valid)
				tx_frame_r <= tx_frame_nxt;
		end
	end

	// ****************************************************************
	// Latched maintenance actions
	// ****************************************************************
	// Actions start only on the third identical recognised frame.
	always_comb
	begin
		act_set = '0;
		if (reached && recog)
		begin
			unique case (fr_code)
				ntm_pkg::MSG_LOOP_ALL: act_set[ntm_pkg::ST_LOOP_ALL] = 1'b1;
				ntm_pkg::MSG_LOOP_B1:  act_set[ntm_pkg::ST_LOOP_B1]  = 1'b1;
				ntm_pkg::MSG_LOOP_B2:  act_set[ntm_pkg::ST_LOOP_B2]  = 1'b1;
				ntm_pkg::MSG_CRC_REQ:  act_set[ntm_pkg::ST_CRC_REQ]  = 1'b1;
				ntm_pkg::MSG_CRC_NOTE: act_set[ntm_pkg::ST_CRC_NOTE] = 1'b1;
				default:               act_set = '0;
			endcase
		end
	end

	// Return to normal clears; a set in the same cycle still wins.
	assign act_clr = rtn_cmd || rtn_sw;
	always_ff @(posedge clk)
	begin
		if (!rst_n || xcvr_reset)
			act_r <= '0;
		else
			act_r <= (act_clr ? '0 : act_r) | act_set;
	end

	assign loop_all                   = act_r[ntm_pkg::ST_LOOP_ALL];
	assign loop_first_bearer_channel  = act_r[ntm_pkg::ST_LOOP_B1];
	assign loop_second_bearer_channel = act_r[ntm_pkg::ST_LOOP_B2];
	assign crc_corrupt                = act_r[ntm_pkg::ST_CRC_REQ];
	assign crc_corrupt_expected       = act_r[ntm_pkg::ST_CRC_NOTE];
	assign eoc_tx_frame               = tx_frame_r;
	assign eoc_tx_valid               = tx_valid_r;

	// ****************************************************************
	// Receive path: descrambler, taps at five and 23
	// ****************************************************************
	assign dn_if.din       = rx_line_bit;
	assign dn_if.din_valid = rx_line_valid;
	assign dn_if.freeze    = rx_frame_sync_word;
	assign dn_if.seed_load = seed_ld;
	assign dn_if.seed      = seed_r;

	ntm_scrambler #(
		.TAP     (ntm_pkg::TAP_DOWN),
		.DESCRAM (1'b1)
	) u_descr (
		.clk   (clk),
		.rst_n (rst_n),
		.io    (dn_if)
	);

	// Slot code follows its bit through the descrambler delay.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rx_chan_r <= ntm_pkg::CH_B1;
		else
			rx_chan_r <= rx_chan;
	end

	// Last descrambled bit of each slot, the loopback source.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			lb_mem_r <= 4'hF;
		else if (dn_if.dout_valid)
			lb_mem_r[rx_chan_r] <= dn_if.dout;
	end

	assign rx_user_bit   = dn_if.dout;
	assign rx_user_valid = dn_if.dout_valid;
	assign rx_user_chan  = rx_chan_r;

	// ****************************************************************
	// Transmit path: scrambler, taps at 18 and 23
	// ****************************************************************
	// Looped slots replace user bits; overhead bits stay the user's.
	assign tx_in = chan_looped(tx_chan, act_r) ? lb_mem_r[tx_chan] : tx_user_bit;
	assign up_if.din       = tx_in;
	assign up_if.din_valid = tx_user_valid;
	assign up_if.freeze    = tx_frame_sync_word;
	assign up_if.seed_load = seed_ld;
	assign up_if.seed      = seed_r;

	ntm_scrambler #(
		.TAP     (ntm_pkg::TAP_UP),
		.DESCRAM (1'b0)
	) u_scr (
		.clk   (clk),
		.rst_n (rst_n),
		.io    (up_if)
	);

	assign tx_line_bit   = up_if.dout;
	assign tx_line_valid = up_if.dout_valid;

	// ****************************************************************
	// APB register file
	// ****************************************************************
	assign wr_en    = psel && penable && pwrite;
	assign rd_en    = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign unmapped = !(paddr inside {ntm_pkg::ADDR_CTRL, ntm_pkg::ADDR_STAT,
		ntm_pkg::ADDR_RXF, ntm_pkg::ADDR_TXF, ntm_pkg::ADDR_SEED});
	assign pslverr  = psel && penable && unmapped;
	assign prdata   = prdata_r;
	// Command pulses from a control write; they store nothing.
	assign rtn_sw  = wr_en && (paddr == ntm_pkg::ADDR_CTRL) && pwdata[ntm_pkg::CTRL_RTN];
	assign seed_ld = wr_en && (paddr == ntm_pkg::ADDR_CTRL) && pwdata[ntm_pkg::CTRL_SEED_LD];
	// Control bits that steer the decoder.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ctrl_r <= ntm_pkg::CTRL_RST;
		else if (wr_en && paddr == ntm_pkg::ADDR_CTRL)
			ctrl_r <= {pwdata[ntm_pkg::CTRL_BLOOP_EN], 1'b0};
	end

	// Seed for both shift registers; an all-ones seed is refused.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			seed_r <= ntm_pkg::SEED_RST;
		else if (wr_en && paddr == ntm_pkg::ADDR_SEED && pwdata[22:0] != ntm_pkg::SEED_ONES)
			seed_r <= pwdata[22:0];
	end
	// Read multiplexer.
	always_comb
	begin
		rd_data = 32'h00000000;
		unique case (paddr)
			ntm_pkg::ADDR_CTRL: rd_data[1:0]  = ctrl_r;
			ntm_pkg::ADDR_STAT: rd_data[6:0]  = {rep_r, act_r};
			ntm_pkg::ADDR_RXF:  rd_data[11:0] = last_rx_r;
			ntm_pkg::ADDR_TXF:  rd_data[11:0] = tx_frame_r;
			ntm_pkg::ADDR_SEED: rd_data[22:0] = seed_r;
			default:            rd_data = 32'h00000000;
		endcase
	end

	// Read data is caught in the setup cycle and stands in the access.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			prdata_r <= 32'h00000000;
		else if (rd_en)
			prdata_r <= rd_data;
	end

endmodule

// >>> ntm_monitor.sv
// Concurrent checks on the block's top ports.
module ntm_monitor (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [11:0] eoc_rx_frame,
	input wire logic        eoc_rx_valid,
	input wire logic [11:0] eoc_tx_frame,
	input wire logic        eoc_tx_valid,
	input wire logic        xcvr_reset,
	input wire logic        rx_line_bit,
	input wire logic        rx_line_valid,
	input wire logic        rx_frame_sync_word,
	input wire logic        rx_user_bit,
	input wire logic        rx_user_valid,
	input wire logic        tx_user_bit,
	input wire logic        tx_user_valid,
	input wire logic        tx_frame_sync_word,
	input wire logic        tx_line_bit,
	input wire logic        tx_line_valid,
	input wire logic        loop_all,
	input wire logic        loop_first_bearer_channel,
	input wire logic        loop_second_bearer_channel,
	input wire logic        crc_corrupt,
	input wire logic        crc_corrupt_expected
);
	// ****************************************************************
	// Helper logic and properties
	// ****************************************************************
	logic [4:0]  acts;
	logic        lp;
	logic        fw_q;
	logic [22:0] hist;
	logic [4:0]  cnt;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Latched actions gathered into one vector.
	assign acts = {crc_corrupt_expected, crc_corrupt, loop_second_bearer_channel,
		loop_first_bearer_channel, loop_all};
	assign lp = loop_all | loop_first_bearer_channel | loop_second_bearer_channel;

	// Shadow of the upstream scrambler, fed from its own output bits.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt  <= 5'h00;
			fw_q <= 1'b0;
		end
		else
		begin
			if (tx_user_valid)
				fw_q <= tx_frame_sync_word;
			if (tx_line_valid && !fw_q)
			begin
				hist <= {hist[21:0], tx_line_bit};
				if (cnt != 5'h17)
					cnt <= cnt + 5'h01;
			end
		end
	end

	property p_reply; eoc_rx_valid && !xcvr_reset |=> eoc_tx_valid; endproperty
	property p_nospont; eoc_tx_valid |-> $past(eoc_rx_valid); endproperty
	property p_badaddr;
		eoc_rx_valid && !xcvr_reset && eoc_rx_frame[11:9] inside {[3'h1:3'h6]}
		|=> eoc_tx_frame == 12'h100 && $stable(acts);
	endproperty
	property p_utc;
		eoc_tx_valid && eoc_tx_frame != $past(eoc_rx_frame)
		|-> eoc_tx_frame inside {12'h1AA, 12'h100};
	endproperty
	property p_hold; eoc_rx_valid && eoc_rx_frame[8:0] == 9'h100 && !xcvr_reset |=> $stable(acts);
	endproperty
	property p_xrst; xcvr_reset |=> acts == 5'h00; endproperty
	property p_rise; $rose(loop_all) |-> $past(eoc_rx_valid) && $past(eoc_rx_frame[8:0]) == 9'h150;
	endproperty
	property p_rxfrz;
		rx_line_valid && rx_frame_sync_word |=> rx_user_valid && rx_user_bit == $past(rx_line_bit);
	endproperty
	property p_txfrz;
		tx_user_valid && tx_frame_sync_word && !lp |=> tx_line_valid && tx_line_bit == $past(tx_user_bit);
	endproperty
	property p_txscr;
		tx_line_valid && !fw_q && cnt == 5'h17 && !lp
		|-> tx_line_bit == ($past(tx_user_bit) ^ hist[17] ^ hist[22]);
	endproperty

	a_reply: assert property (p_reply) else $error("Reply strobe missing.");
	a_nospont: assert property (p_nospont) else $error("Spontaneous reply.");
	a_badaddr: assert property (p_badaddr) else $error("Foreign address not held.");
	a_utc: assert property (p_utc) else $error("Bad non-echo reply.");
	a_hold: assert property (p_hold) else $error("Hold changed actions.");
	a_xrst: assert property (p_xrst) else $error("Reset state kept actions.");
	a_rise: assert property (p_rise) else $error("Loop without command.");
	a_rxfrz: assert property (p_rxfrz) else $error("Descrambler not frozen.");
	a_txfrz: assert property (p_txfrz) else $error("Scrambler not frozen.");
	a_txscr: assert property (p_txscr) else $error("Upstream taps wrong.");

	c_loop: cover property ($rose(loop_all));
	c_utc: cover property (eoc_tx_valid && eoc_tx_frame == 12'h1AA);
	c_frz: cover property (rx_line_valid && rx_frame_sync_word);
endmodule

bind ntm_top ntm_monitor u_mon (.clk, .rst_n, .eoc_rx_frame, .eoc_rx_valid, .eoc_tx_frame,
	.eoc_tx_valid, .xcvr_reset, .rx_line_bit, .rx_line_valid, .rx_frame_sync_word, .rx_user_bit,
	.rx_user_valid, .tx_user_bit, .tx_user_valid, .tx_frame_sync_word, .tx_line_bit,
	.tx_line_valid, .loop_all, .loop_first_bearer_channel, .loop_second_bearer_channel,
	.crc_corrupt, .crc_corrupt_expected);

// >>> ntm_lt_model.sv
// Line termination model: downstream scrambler, upstream descrambler.
module ntm_lt_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic go,
	input  wire logic ubit,
	input  wire logic fw,
	output logic      line_bit,
	output logic      line_valid,
	input  wire logic up_bit,
	input  wire logic up_valid,
	input  wire logic up_fw,
	output logic      rec_bit,
	output logic      rec_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Scrambler and descrambler
	// ****************************************************************
	logic [22:0] s_r;
	logic [22:0] d_r;

	// Downstream scrambler; the idle line toggles.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_r        <= 23'h2A5A5A;
			line_valid <= 1'b0;
			line_bit   <= 1'b0;
		end
		else if (go)
		begin
			line_bit   <= fw ? ubit : ubit ^ s_r[4] ^ s_r[22];
			line_valid <= 1'b1;
			if (!fw)
				s_r <= {s_r[21:0], ubit ^ s_r[4] ^ s_r[22]};
		end
		else
		begin
			line_valid <= 1'b0;
			line_bit   <= ~line_bit;
		end
	end

	// Upstream descrambler, self-synchronising on the received bits.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			d_r       <= 23'h000000;
			rec_valid <= 1'b0;
		end
		else
		begin
			rec_valid <= up_valid;
			if (up_valid)
				rec_bit <= up_fw ? up_bit : up_bit ^ d_r[17] ^ d_r[22];
			if (up_valid && !up_fw)
				d_r <= {d_r[21:0], up_bit};
		end
	end
endmodule

// >>> ntm_tb.sv
// Self-checking testbench for the maintenance message and scrambler block.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module nt_maintenance_msg_and_scrambler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// Signals, design, partner and tasks
	// ****************************************************************
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err, m_go, m_bit;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [11:0] eoc_rx_frame, eoc_tx_frame, last;
	logic        eoc_rx_valid, eoc_tx_valid, xcvr_reset, rec_bit, rec_valid;
	logic        rx_line_bit, rx_line_valid, rx_frame_sync_word, rx_user_bit, rx_user_valid;
	logic [1:0]  rx_chan, rx_user_chan, tx_chan;
	logic        tx_user_bit, tx_user_valid, tx_frame_sync_word, tx_line_bit, tx_line_valid;
	logic        loop_all, loop_first_bearer_channel, loop_second_bearer_channel;
	logic        crc_corrupt, crc_corrupt_expected;
	logic [4:0]  act;
	int          bad_count, n_tests, cyc, cnt, nbits;
	logic [11:0] cmds [3] = '{12'h150, 12'hF51, 12'h152};
	logic [2:0]  lps [3] = '{3'h7, 3'h1, 3'h2};
	logic [3:0]  blks [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
	logic [11:0] pool [6] = '{12'h150, 12'h153, 12'h1FF, 12'hF00, 12'h750, 12'h1AB};

	ntm_top uut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
		.pslverr, .eoc_rx_frame, .eoc_rx_valid, .eoc_tx_frame, .eoc_tx_valid, .xcvr_reset,
		.rx_line_bit, .rx_line_valid, .rx_frame_sync_word, .rx_chan, .rx_user_bit,
		.rx_user_valid, .rx_user_chan, .tx_user_bit, .tx_user_valid, .tx_frame_sync_word,
		.tx_chan, .tx_line_bit, .tx_line_valid, .loop_all, .loop_first_bearer_channel,
		.loop_second_bearer_channel, .crc_corrupt, .crc_corrupt_expected);
	ntm_lt_model lt (.clk, .rst_n, .go(m_go), .ubit(m_bit),
		.fw(rx_frame_sync_word), .line_bit(rx_line_bit), .line_valid(rx_line_valid),
		.up_bit(tx_line_bit), .up_valid(tx_line_valid), .up_fw(tx_frame_sync_word),
		.rec_bit(rec_bit), .rec_valid(rec_valid));

	// Clock and hang guard.
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		if (++cyc == 30000)
		begin
			bad_count++;
			results();
		end
	end

	// Prints counts and verdict, then stops.
	task results;
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One APB transfer; read data and error taken at the pready edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask

	// Recognised message codes.
	function automatic logic known(input logic [11:0] f);
		return f[8] && f[7:0] inside {8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'hFF, 8'h00};
	endfunction

	// Sends one frame; checks reply and actions.
	task frame(input logic [11:0] f);
		logic        ok;
		logic [11:0] er;
		ok = f[11:9] == 3'h0 || f[11:9] == 3'h7;
		cnt = !ok ? 0 : (f == last) ? cnt + 1 : 1;
		last = f;
		er = !ok ? 12'h100 : (cnt >= 3 && !known(f)) ? 12'h1AA : f;
		if (ok && cnt >= 3 && known(f))
		begin
			if (f[7:0] == 8'hFF)
				cnt = 0;
			act = (f[7:0] == 8'hFF) ? 5'h00 : (f[7:4] == 4'h5) ? act | (5'h01 << f[2:0]) : act;
		end
		@(posedge clk);
		{eoc_rx_frame, eoc_rx_valid} <= {f, 1'b1};
		@(posedge clk);
		eoc_rx_valid <= 1'b0;
		#1;
		`CHK("reply valid", 1'b1, eoc_tx_valid)
		`CHK("reply", er, eoc_tx_frame)
		`CHK("actions", act, {crc_corrupt_expected, crc_corrupt, loop_second_bearer_channel,
			loop_first_bearer_channel, loop_all})
	endtask

	// Bit traffic both ways; lp marks looped slots.
	task bits(input int n, input logic [2:0] lp, input logic fwok);
		logic       r, u, fw;
		logic [1:0] ch;
		for (int i = 0; i < n; i++)
		begin
			{r, u, ch} = 4'($urandom);
			fw = fwok && (i % 7 == 3);
			@(posedge clk);
			{m_go, m_bit, rx_chan, rx_frame_sync_word} <= {1'b1, r, ch, fw};
			@(posedge clk);
			m_go <= 1'b0;
			@(posedge clk);
			#1;
			nbits += !fw;
			if (nbits > 30)
				`CHK("rx bit", r, rx_user_bit)
			`CHK("rx slot", ch, rx_user_chan)
			@(posedge clk);
			{tx_user_valid, tx_user_bit, tx_chan, tx_frame_sync_word} <= {1'b1, u, ch, fw};
			@(posedge clk);
			tx_user_valid <= 1'b0;
			@(posedge clk);
			#1;
			if (nbits > 30)
				`CHK("tx bit", (ch != 2'h3 && lp[ch]) ? r : u, rec_bit)
		end
	endtask

	// Main sequence.
	initial
	begin
		clk = 1'b0;
		{rst_n, psel, penable, pwrite, eoc_rx_valid, xcvr_reset, m_go, m_bit} = '0;
		{tx_user_valid, tx_user_bit, tx_frame_sync_word, rx_frame_sync_word} = '0;
		{paddr, pwdata, eoc_rx_frame, rx_chan, tx_chan, last, act} = '0;
		void'($urandom(42));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK("reset reply", 12'h100, eoc_tx_frame)
		apb(1'b0, ntm_pkg::ADDR_CTRL, 32'h0);
		`CHK("ctrl", 32'h2, rd)
		apb(1'b1, ntm_pkg::ADDR_SEED, 32'h7FFFFF);
		apb(1'b0, ntm_pkg::ADDR_SEED, 32'h0);
		`CHK("seed", 32'h1, rd)
		apb(1'b0, 8'h14, 32'h0);
		`CHK("unmapped", 1'b1, err)
		apb(1'b1, ntm_pkg::ADDR_SEED, {9'h000, 23'($urandom) & 23'h7FFFFE});
		apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h6);
		bits(40, 3'h0, 1'b1);
		for (int k = 0; k < 3; k++)
		begin
			repeat (3) frame(cmds[k]);
			bits(24, lps[k], 1'b0);
			repeat (3) frame(12'h100);
			repeat (4) frame(12'h1FF);
		end
		repeat (3) frame(12'h153);
		repeat (3) frame(12'h154);
		for (int a = 1; a < 7; a++)
			frame({3'(a), 9'h153});
		for (int k = 0; k < 10; k++)
			repeat (4) frame({k[0] ? 3'h7 : 3'h0, k != 9, k < 8 ? blks[k] : 4'hC, 4'(k)});
		apb(1'b1, ntm_pkg::ADDR_CTRL, 32'h3);
		act = 5'h00;
		repeat (3) frame(12'h153);
		@(posedge clk);
		xcvr_reset <= 1'b1;
		@(posedge clk);
		xcvr_reset <= 1'b0;
		{act, cnt} = '0;
		for (int k = 0; k < 60; k++)
			frame(pool[$urandom % 6]);
		results();
	end
endmodule
